// *** include/tscr_pkg.sv ***
/*
 * Constants, field layouts and carrier types for the transceiver status
 * and configuration register bank.
 * Assumes the bank sits behind a 16-bit serial command port.
 */
// Function
// R1: Reading the status word clears every event flag that the read reported
// R2: Write commands start with a one; only the status read starts with zero
// R3: Bit 15 means tx register ready in transmit, fifo fill level in receive
// R4: Bit 14 set after power-on, bit 12 on wake timer, bit 10 low supply
// R5: Bit 13 flags tx underrun or overwrite, or rx fifo overflow
// R6: Bit 11 set on a high-to-low edge of the interrupt pin
// R7: Bit 9 reads one while the receive fifo is empty
// R8: Bit 8 means strong antenna signal in tx, above rssi threshold in rx
// R9: Bit 7 reports good data quality, bit 6 reports clock recovery lock
// R10: Bit 5 toggles once per completed frequency correction cycle
// R11: Offset is two's complement, sign in bit 4, magnitude in bits 3 to 0
// R12: Host turns offset calculation off before reading the status word
// R13: Upper byte 80h writes general config, c4h writes correction config
// R14: General config bit 7 enables the internal transmit byte register
// R15: General config bit 6 enables the receive fifo, else data goes to pins
// R16: Band field 11/10/01 picks 915/868/433 MHz; load 8.5 to 16 pF
// R17: Host holds data select pin high for tx register, low for fifo
// R18: Correction mode selects always, receive only, once, or host control
// R19: Range field limits correction to 3/4, 7/8, 15/16 steps or none
// R20: Strobe bit takes one offset sample; host clears it before the next
// R21: Fine accuracy doubles processing time for a smaller uncertainty
// R22: Bit 0 enables offset calculation, bit 1 adds offset to synthesizer
// R23: Chip select low for whole 16-bit word; data sampled on rising edges
// R24: Words go most significant bit first; device drives on falling edges
// R25: A cleared event flag sets again on the next occurrence of its cause
`default_nettype none
package tscr_pkg;
  localparam int          WORD_BITS = 16;
  localparam logic [7:0]  CMD_GEN   = 8'h80;
  localparam logic [7:0]  CMD_AFC   = 8'hc4;
  localparam logic [15:0] GEN_RST   = 16'h8008;
  localparam logic [15:0] AFC_RST   = 16'hc4f7;
  localparam logic [15:0] STAT_RST  = 16'h0000;
  // Sticky event flags: 0 tx/rx, 1 power-on, 2 overflow, 3 wake, 4 pin fall
  localparam logic [4:0]  EV_RST    = 5'h02;
  localparam int          EV_TXRX   = 0;
  localparam int          EV_POR    = 1;
  localparam int          EV_OVF    = 2;
  localparam int          EV_WAKE   = 3;
  localparam int          EV_FALL   = 4;
  // Field positions inside the lower command byte
  localparam int G_TXEN  = 7;
  localparam int G_RXQ   = 6;
  localparam int G_BAND  = 4;
  localparam int G_LOAD  = 0;
  localparam int A_MODE  = 6;
  localparam int A_RANGE = 4;
  localparam int A_STRB  = 3;
  localparam int A_FINE  = 2;
  localparam int A_APPLY = 1;
  localparam int A_CALC  = 0;
  // Band tuning step in hertz
  localparam logic [12:0] STEP_433_HZ = 13'h09c4;
  localparam logic [12:0] STEP_868_HZ = 13'h1388;
  localparam logic [12:0] STEP_915_HZ = 13'h1d4c;

  typedef enum logic [1:0] {
    BAND_RSVD = 2'h0, BAND_433 = 2'h1, BAND_868 = 2'h2, BAND_915 = 2'h3
  } tscr_band_e;
  typedef enum logic [1:0] {
    MODE_HOST = 2'h0, MODE_ONCE = 2'h1, MODE_RX = 2'h2, MODE_ALWAYS = 2'h3
  } tscr_mode_e;
  typedef enum logic [1:0] {
    RANGE_FREE = 2'h0, RANGE_16 = 2'h1, RANGE_8 = 2'h2, RANGE_4 = 2'h3
  } tscr_range_e;

  typedef struct packed {
    logic       tx_mode;
    logic       tx_ready;
    logic       rx_fill_hit;
    logic       tx_underrun;
    logic       rx_overflow;
    logic       wake_ovf;
    logic       low_supply;
    logic       rx_empty;
    logic       ant_strong;
    logic       rssi_above;
    logic       good_quality;
    logic       recovery_lock;
    logic       corr_done;
    logic [4:0] offset;
  } tscr_stat_s;

  typedef struct packed {
    logic        tx_byte_reg_enable;
    logic        rx_queue_enable;
    tscr_band_e  band_select;
    logic [3:0]  crystal_load_select;
    tscr_mode_e  correction_mode;
    tscr_range_e offset_range_limit;
    logic        fine_accuracy_select;
    logic        offset_apply_enable;
    logic        offset_calc_enable;
  } tscr_cfg_s;
endpackage
`default_nettype wire

// *** src/tscr_regs.sv ***
/*
 * Status word, general configuration and frequency correction
 * configuration registers behind the 16-bit serial command port.
 * Assumes status sources run on i_clk, the serial clock only toggles
 * while chip select is low, and chip select falls at least three i_clk
 * periods before the first serial clock rise.
 */
`default_nettype none
module tscr_regs #(
  parameter int WORD_W = 16
) (
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  input  wire logic                i_sck,
  input  wire logic                i_cs_n,
  input  wire logic                i_sdi,
  output logic                     o_sdo,
  output logic                     o_sdo_oe,
  input  wire logic                i_irq_pin,
  input  wire tscr_pkg::tscr_stat_s i_stat,
  output tscr_pkg::tscr_cfg_s      o_cfg,
  output logic                     o_manual_sample,
  output logic [4:0]               o_applied_offset,
  output logic [12:0]              o_tuning_step_hz,
  output logic [15:0]              o_status_word
);

  // Elaboration check on the word width
  if (WORD_W != tscr_pkg::WORD_BITS) begin : g_bad_width
    $error("tscr_regs serves 16-bit command words only");
  end

  // ********************************************************************
  // Helper functions
  // ********************************************************************

  // Matches the upper command byte of a received word
  function automatic logic cmd_hit(input logic [15:0] w,
                                   input logic [7:0]  code);
    cmd_hit = (w[15:8] == code);
  endfunction

  // Largest positive offset for a range setting
  function automatic logic signed [4:0] range_top(
      input tscr_pkg::tscr_range_e r);
    case (r)
      tscr_pkg::RANGE_4:  range_top = 5'sd3;
      tscr_pkg::RANGE_8:  range_top = 5'sd7;
      default:            range_top = 5'sd15;
    endcase
  endfunction

  // Clamps a signed offset into the allowed correction window
  function automatic logic [4:0] clamp_off(input logic [4:0] off,
      input tscr_pkg::tscr_range_e r);
    logic signed [4:0] v;
    logic signed [4:0] top;
    v   = off;
    top = range_top(r);
    if (v > top) begin
      clamp_off = top;
    end else if (v < -top - 5'sd1) begin
      clamp_off = -top - 5'sd1;
    end else begin
      clamp_off = v;
    end
  endfunction

  // ********************************************************************
  // Serial clock domain
  // ********************************************************************

  logic        link_rst;
  logic [3:0]  bit_cnt_q;
  logic [14:0] shift_q;
  logic [15:0] word_q;
  logic        done_tgl_q;
  logic        sdo_q;
  logic [15:0] snap_q;

  // Chip select high holds the shifter idle
  assign link_rst = i_rst | i_cs_n;

  // Bit counter and shifter, sampled on rising edges while selected
  always_ff @(posedge i_sck or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt_q <= 4'h0;
      shift_q   <= 15'h0000;
    end else begin
      bit_cnt_q <= bit_cnt_q + 4'h1; // R23
      shift_q   <= {shift_q[13:0], i_sdi}; // R24
    end
  end

  // Whole word capture, announced to the system side by a toggle
  always_ff @(posedge i_sck or posedge i_rst) begin
    if (i_rst) begin
      word_q     <= 16'h0000;
      done_tgl_q <= 1'b0;
    end else if (!i_cs_n && bit_cnt_q == 4'hf) begin
      word_q     <= {shift_q, i_sdi}; // R23
      done_tgl_q <= ~done_tgl_q;
    end
  end

  // Frozen status snapshot leaves most significant bit first
  always_ff @(negedge i_sck or posedge link_rst) begin
    if (link_rst) begin
      sdo_q <= 1'b0;
    end else begin
      sdo_q <= snap_q[4'hf - bit_cnt_q]; // R24
    end
  end

  // Pin driven only while selected, low otherwise
  assign o_sdo_oe = ~i_cs_n;
  assign o_sdo    = ~i_cs_n & ((bit_cnt_q == 4'h0) ? snap_q[15] : sdo_q);

  // ********************************************************************
  // Crossings into the system clock
  // ********************************************************************

  logic tgl_s1_q;
  logic tgl_s2_q;
  logic tgl_s3_q;
  logic cs_s1_q;
  logic cs_s2_q;
  logic irq_s1_q;
  logic irq_s2_q;
  logic irq_s3_q;
  logic cmd_stb;

  // Two-stage synchronisers, third stage only for edge detection
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
      cs_s1_q  <= 1'b1;
      cs_s2_q  <= 1'b1;
      irq_s1_q <= 1'b1;
      irq_s2_q <= 1'b1;
      irq_s3_q <= 1'b1;
    end else begin
      tgl_s1_q <= done_tgl_q;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
      cs_s1_q  <= i_cs_n;
      cs_s2_q  <= cs_s1_q;
      irq_s1_q <= i_irq_pin;
      irq_s2_q <= irq_s1_q;
      irq_s3_q <= irq_s2_q;
    end
  end

  // One pulse per received word; word_q stays still for 16 serial clocks
  assign cmd_stb = tgl_s2_q ^ tgl_s3_q;

  // ********************************************************************
  // Command decode and configuration registers
  // ********************************************************************

  logic        rd_stb;
  logic        gen_wr;
  logic        afc_wr;
  logic [7:0]  gen_q;
  logic [7:0]  afc_q;
  logic        sample_q;

  assign rd_stb = cmd_stb & ~word_q[15]; // R2
  assign gen_wr = cmd_stb & cmd_hit(word_q, tscr_pkg::CMD_GEN); // R13
  assign afc_wr = cmd_stb & cmd_hit(word_q, tscr_pkg::CMD_AFC); // R13

  // General configuration, lower byte only
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      gen_q <= tscr_pkg::GEN_RST[7:0];
    end else if (gen_wr) begin
      gen_q <= word_q[7:0]; // R13
    end
  end

  // Frequency correction configuration, lower byte only
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      afc_q <= tscr_pkg::AFC_RST[7:0];
    end else if (afc_wr) begin
      afc_q <= word_q[7:0]; // R13
    end
  end

  // One sample per rising strobe; host must clear it to rearm
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sample_q <= 1'b0;
    end else begin
      sample_q <= afc_wr & word_q[tscr_pkg::A_STRB]
                  & ~afc_q[tscr_pkg::A_STRB]; // R20
    end
  end

  // Field split of both configuration registers
  always_comb begin
    o_cfg.tx_byte_reg_enable   = gen_q[tscr_pkg::G_TXEN]; // R14
    o_cfg.rx_queue_enable      = gen_q[tscr_pkg::G_RXQ]; // R15
    o_cfg.band_select          =
      tscr_pkg::tscr_band_e'(gen_q[tscr_pkg::G_BAND +: 2]); // R16
    o_cfg.crystal_load_select  = gen_q[tscr_pkg::G_LOAD +: 4]; // R16
    o_cfg.correction_mode      =
      tscr_pkg::tscr_mode_e'(afc_q[tscr_pkg::A_MODE +: 2]); // R18
    o_cfg.offset_range_limit   =
      tscr_pkg::tscr_range_e'(afc_q[tscr_pkg::A_RANGE +: 2]); // R19
    o_cfg.fine_accuracy_select = afc_q[tscr_pkg::A_FINE]; // R21
    o_cfg.offset_apply_enable  = afc_q[tscr_pkg::A_APPLY]; // R22
    o_cfg.offset_calc_enable   = afc_q[tscr_pkg::A_CALC]; // R22
  end
  assign o_manual_sample = sample_q;

  // ********************************************************************
  // Offset handling and band step
  // ********************************************************************

  logic [4:0]  applied_q;
  logic [12:0] step_q;

  // Stored offset reaches the synthesizer only when enabled, clamped
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      applied_q <= 5'h00;
    end else if (!o_cfg.offset_apply_enable) begin
      applied_q <= 5'h00; // R22
    end else if (o_cfg.offset_range_limit == tscr_pkg::RANGE_FREE) begin
      applied_q <= i_stat.offset; // R19
    end else begin
      applied_q <= clamp_off(i_stat.offset, o_cfg.offset_range_limit); // R19
    end
  end

  // Tuning step for the selected band
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      step_q <= 13'h0000;
    end else begin
      case (o_cfg.band_select)
        tscr_pkg::BAND_433: step_q <= tscr_pkg::STEP_433_HZ; // R16
        tscr_pkg::BAND_868: step_q <= tscr_pkg::STEP_868_HZ;
        tscr_pkg::BAND_915: step_q <= tscr_pkg::STEP_915_HZ;
        default:            step_q <= 13'h0000;
      endcase
    end
  end
  assign o_applied_offset = applied_q;
  assign o_tuning_step_hz = step_q;

  // ********************************************************************
  // Status word
  // ********************************************************************

  logic [4:0]  ev_q;
  logic [4:0]  ev_set;
  logic [4:0]  ev_clr;
  logic        cyc_tgl_q;
  logic [15:0] stat_q;

  // Event causes; tx/rx and overflow causes multiplexed by transmit or receive mode
  always_comb begin
    ev_set                   = 5'h00;
    ev_set[tscr_pkg::EV_TXRX] = i_stat.tx_mode ? i_stat.tx_ready
                                              : i_stat.rx_fill_hit; // R3
    ev_set[tscr_pkg::EV_OVF]  = i_stat.tx_mode ? i_stat.tx_underrun
                                              : i_stat.rx_overflow; // R5
    ev_set[tscr_pkg::EV_WAKE] = i_stat.wake_ovf; // R4
    ev_set[tscr_pkg::EV_FALL] = irq_s3_q & ~irq_s2_q; // R6
  end

  // Read clears only what the snapshot reported
  assign ev_clr = rd_stb ? {snap_q[11], snap_q[12], snap_q[13],
                            snap_q[14], snap_q[15]} : 5'h00; // R1

  // Sticky flags, a new cause wins over a clear in the same cycle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ev_q <= tscr_pkg::EV_RST; // R4
    end else begin
      ev_q <= (ev_q & ~ev_clr) | ev_set; // R25
    end
  end

  // One toggle per finished correction cycle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cyc_tgl_q <= 1'b0;
    end else if (i_stat.corr_done) begin
      cyc_tgl_q <= ~cyc_tgl_q; // R10
    end
  end

  // Live status word
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      stat_q <= tscr_pkg::STAT_RST;
    end else begin
      stat_q <= {ev_q[tscr_pkg::EV_TXRX], ev_q[tscr_pkg::EV_POR],
                 ev_q[tscr_pkg::EV_OVF], ev_q[tscr_pkg::EV_WAKE],
                 ev_q[tscr_pkg::EV_FALL], i_stat.low_supply, // R4
                 i_stat.rx_empty, // R7
                 i_stat.tx_mode ? i_stat.ant_strong
                                : i_stat.rssi_above, // R8
                 i_stat.good_quality, i_stat.recovery_lock, // R9
                 cyc_tgl_q, i_stat.offset}; // R11
    end
  end

  // Snapshot follows while deselected and holds during a transfer
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      snap_q <= tscr_pkg::STAT_RST;
    end else if (cs_s2_q) begin
      snap_q <= stat_q;
    end
  end
  assign o_status_word = stat_q;

  // ********************************************************************
  // Assertions
  // ********************************************************************

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_read_clears_wake: assert property ( // R1
    rd_stb && snap_q[12] && !i_stat.wake_ovf |=> !ev_q[tscr_pkg::EV_WAKE])
    else $error("wake flag survived a status read");
  a_read_keeps_cfg: assert property ( // R2
    rd_stb |=> $stable(gen_q) && $stable(afc_q))
    else $error("status read changed configuration");
  a_gen_write_lands: assert property ( // R13
    gen_wr |=> gen_q == $past(word_q[7:0]))
    else $error("general config write lost");
  a_txrx_flag_sets: assert property ( // R3
    i_stat.tx_mode && i_stat.tx_ready |=> ##1 stat_q[15])
    else $error("tx ready flag missing from status");
  a_pin_fall_flag: assert property ( // R6
    irq_s3_q && !irq_s2_q |=> ev_q[tscr_pkg::EV_FALL])
    else $error("pin fall not flagged");
  a_cycle_toggles: assert property ( // R10
    i_stat.corr_done |=> cyc_tgl_q != $past(cyc_tgl_q))
    else $error("correction toggle did not flip");
  a_strobe_pulse: assert property ( // R20
    afc_wr && word_q[3] && !afc_q[3] |=> o_manual_sample ##1 !o_manual_sample)
    else $error("manual sample pulse wrong");
  a_apply_gate: assert property ( // R22
    !o_cfg.offset_apply_enable |=> o_applied_offset == 5'h00)
    else $error("offset applied while disabled");
  a_range_four: assert property ( // R19
    o_cfg.offset_apply_enable && afc_q[5:4] == 2'h3 && $stable(afc_q)
    |=> $signed(o_applied_offset) <= 5'sd3
        && $signed(o_applied_offset) >= -5'sd4)
    else $error("offset outside four step window");
  a_word_done: assert property ( // R23
    @(negedge i_sck) disable iff (link_rst)
    bit_cnt_q == 4'h0 |-> done_tgl_q != $past(done_tgl_q))
    else $error("sixteenth bit did not complete a word");

endmodule
`default_nettype wire

// *** test/tscr_host.sv ***
/*
 * Host model: serial master that frames 16-bit command words.
 * Assumes the bench calls xfer and the device samples on sck rise.
 */
`default_nettype none
module tscr_host (
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_sdi,
  input  wire logic i_sdo
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Link idle state and word framing
  // ****************************************
  // Clock stands low and device deselected between frames
  initial begin
    o_sck  = 1'h0;
    o_cs_n = 1'h1;
    o_sdi  = 1'h0;
  end

  // One word at a 64 ns link clock, selected for all 16 bits
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    o_cs_n = 1'h0;
    #100;
    for (int i = 15; i >= 0; i--) begin
      o_sdi = w[i];
      #32 o_sck = 1'h1;
      r[i] = i_sdo;
      #32 o_sck = 1'h0;
    end
    #20 o_sdi = ~o_sdi; // Data line inverted after the last bit, before deselect
    o_cs_n = 1'h1;
    #110;
  endtask
endmodule
`default_nettype wire

// *** test/tb.sv ***
/*
 * Self-checking bench for the status and configuration register bank.
 * Assumes the host model drives the serial link at its own clock.
 */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                 i_clk;
  logic                 i_rst;
  logic                 sck;
  logic                 cs_n;
  logic                 sdi;
  logic                 sdo;
  logic                 oe;
  logic                 irq;
  tscr_pkg::tscr_stat_s st;
  tscr_pkg::tscr_cfg_s  cfg;
  logic                 man;
  logic [4:0]           aoff;
  logic [12:0]          step;
  logic [15:0]          sw;
  logic [15:0]          rd;
  logic [7:0]           gen;
  logic [7:0]           afc;
  logic [4:0]           stk;
  logic                 tog;
  logic                 old;
  int                   err_total;
  int                   compares;
  int                   pulses;
  int                   p0;
  int                   oe_hi;

  // 40 MHz system clock
  initial begin
    i_clk = 1'h0;
    forever #12.5 i_clk = ~i_clk;
  end

  tscr_regs dut (.i_clk(i_clk), .i_rst(i_rst), .i_sck(sck),
    .i_cs_n(cs_n), .i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe(oe),
    .i_irq_pin(irq), .i_stat(st), .o_cfg(cfg), .o_manual_sample(man),
    .o_applied_offset(aoff), .o_tuning_step_hz(step),
    .o_status_word(sw));
  tscr_host host (.o_sck(sck), .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(sdo));

  // Count manual sample pulses
  always @(posedge i_clk) if (man === 1'h1) pulses++;

  // Count link clock rises that see the output enabled
  always @(posedge sck) if (oe === 1'h1) oe_hi++;

  // ****************************************
  // Expectation and compare helpers
  // ****************************************
  function automatic logic [15:0] stat_of(input tscr_pkg::tscr_stat_s s,
                                           input logic [4:0] k,
                                           input logic t);
    return {k[0], k[1], k[2], k[3], k[4], s.low_supply, s.rx_empty,
            s.tx_mode ? s.ant_strong : s.rssi_above, s.good_quality,
            s.recovery_lock, t, s.offset};
  endfunction

  function automatic logic [12:0] step_of(input logic [1:0] b);
    case (b)
      2'h1: return tscr_pkg::STEP_433_HZ;
      2'h2: return tscr_pkg::STEP_868_HZ;
      2'h3: return tscr_pkg::STEP_915_HZ;
      default: return 13'h0000;
    endcase
  endfunction

  function automatic logic [4:0] off_of(input logic [7:0] a,
                                        input logic [4:0] o);
    int s;
    int lim;
    s = $signed(o);
    lim = (a[5:4] == 2'h3) ? 4 : (a[5:4] == 2'h2) ? 8 : 16;
    if (a[1] !== 1'h1) return 5'h00;
    if (s > lim - 1) return 5'(lim - 1);
    if (s < -lim) return 5'(-lim);
    return o;
  endfunction

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cfg_chk;
    chk("general", {8'h00, gen}, {8'h00, cfg.tx_byte_reg_enable,
        cfg.rx_queue_enable, cfg.band_select, cfg.crystal_load_select});
    chk("correction", {9'h000, afc[7:4], afc[2:0]},
        {9'h000, cfg.correction_mode, cfg.offset_range_limit,
        cfg.fine_accuracy_select, cfg.offset_apply_enable,
        cfg.offset_calc_enable});
    chk("step", {3'h0, step_of(gen[5:4])}, {3'h0, step});
  endtask

  task automatic conclude;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wr(input logic [15:0] w);
    host.xfer(w, rd);
    repeat (6) @(negedge i_clk);
  endtask

  // Random status levels, event sources idle
  task automatic levels;
    @(negedge i_clk);
    st = 18'($urandom);
    {st.tx_ready, st.rx_fill_hit, st.tx_underrun, st.rx_overflow,
     st.wake_ovf, st.corr_done} = 6'h00;
  endtask

  // One-cycle event pulse and its expected flag
  task automatic pulse(input int k);
    @(negedge i_clk);
    {st.tx_ready, st.rx_fill_hit, st.tx_underrun, st.rx_overflow,
     st.wake_ovf, st.corr_done} = 6'h20 >> k;
    if (k < 4 && st.tx_mode == (k % 2 == 0)) stk[k < 2 ? 0 : 2] = 1'h1;
    if (k == 4) stk[3] = 1'h1;
    if (k == 5) tog = ~tog;
    @(negedge i_clk);
    {st.tx_ready, st.rx_fill_hit, st.tx_underrun, st.rx_overflow,
     st.wake_ovf, st.corr_done} = 6'h00;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(57));
    i_rst = 1'h1;
    irq = 1'h1;
    st = '0;
    gen = 8'h08;
    afc = 8'hf7;
    stk = 5'h02;
    tog = 1'h0;
    err_total = 0;
    compares = 0;
    pulses = 0;
    oe_hi = 0;
    repeat (4) @(negedge i_clk);
    i_rst = 1'h0;
    repeat (2) @(negedge i_clk);
    cfg_chk();
    chk("status", stat_of(st, stk, tog), sw);
    chk("idle", 16'h0000, {14'h0000, oe, sdo});
    for (int i = 0; i < 8; i++) begin
      gen = 8'($urandom);
      gen[5:4] = 2'(i);
      gen[6] = ~gen[7];
      wr({tscr_pkg::CMD_GEN, gen});
      cfg_chk();
    end
    wr({8'h90, ~gen});
    cfg_chk();
    wr({1'h0, 15'($urandom)});
    chk("read", stat_of(st, stk, tog), rd);
    stk = 5'h00;
    cfg_chk();
    for (int i = 0; i < 8; i++) begin
      levels();
      old = afc[3];
      afc = 8'($urandom);
      afc[7:4] = {2'(i), 2'(i >> 1)};
      if (old) afc[3] = 1'h0;
      p0 = pulses;
      wr({tscr_pkg::CMD_AFC, afc});
      cfg_chk();
      chk("sample", 16'(afc[3] & ~old), 16'(pulses - p0));
      chk("offset", {11'h000, off_of(afc, st.offset)}, {11'h000, aoff});
      chk("status", stat_of(st, stk, tog), sw);
    end
    for (int j = 0; j < 4; j++) begin
      levels();
      st.tx_mode = j[0];
      for (int k = 0; k < 6; k++) pulse(k);
      irq = 1'h0;
      stk[4] = 1'h1;
      repeat (6) @(negedge i_clk);
      irq = 1'h1;
      chk("events", stat_of(st, stk, tog), sw);
      afc = afc & 8'hf6;
      wr({tscr_pkg::CMD_AFC, afc});
      p0 = oe_hi;
      host.xfer(16'h0000, rd);
      chk("enable", 16'h0010, 16'(oe_hi - p0));
      chk("read", stat_of(st, stk, tog), rd);
      stk = 5'h00;
      repeat (6) @(negedge i_clk);
      chk("cleared", stat_of(st, stk, tog), sw);
      pulse(4);
      repeat (3) @(negedge i_clk);
      chk("again", stat_of(st, stk, tog), sw);
    end
    conclude();
  end

  // Hang guard
  initial begin
    #1000000;
    err_total++;
    conclude();
  end
endmodule
`default_nettype wire
